// *** rtl/gtc_consts.vh ***
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH
`define GTC_ADDR_COUNT_LO 12'h000
`define GTC_ADDR_COUNT_HI 12'h004
`define GTC_ADDR_CONTROL 12'h008
`define GTC_ADDR_EVENT 12'h00c
`define GTC_ADDR_CMP_LO 12'h010
`define GTC_ADDR_CMP_HI 12'h014
`define GTC_ADDR_INCR 12'h018
`define GTC_ADDR_MASK 12'h01c
`define GTC_CTL_COUNT_EN 0
`define GTC_CTL_CMP_EN 1
`define GTC_CTL_IRQ_EN 2
`define GTC_CTL_AUTO_INC 3
`define GTC_CTL_WIDTH 4
`define GTC_CTL_RESET 4'h0
`define GTC_EVT_MATCH 0
`define GTC_MASK_RESET 1'h1
`endif

// *** rtl/gtc_match.v ***
`timescale 1ns/1ps
`default_nettype none
module gtc_match #(
  parameter W = 64
) (
  input wire [W-1:0] count,
  input wire [W-1:0] compare,
  input wire cmp_en,
  output wire hit
);
  // Reaching means count at or past the comparator value
  assign hit = cmp_en && (count >= compare);
endmodule
`default_nettype wire

// *** rtl/gtc_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "gtc_consts.vh"
module gtc_timer #(
  parameter W = 64
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq
);
  reg rst_meta;
  reg rst_sync_n;
  reg [W-1:0] count;
  reg [W-1:0] compare;
  reg [31:0] incr;
  reg [`GTC_CTL_WIDTH-1:0] control;
  reg event_flag;
  reg mask;
  reg armed;
  reg prev_hit;
  wire hit;
  wire access;
  wire wr;
  wire match_evt;
  reg [31:0] next_rdata;
  reg next_err;
  wire wr_done;
  wire wr_count_lo;
  wire wr_count_hi;
  wire wr_control;
  wire wr_event;
  wire wr_cmp_lo;
  wire wr_cmp_hi;
  wire wr_incr;
  wire wr_mask;
  wire clr_evt;
  wire next_event_flag;
  wire [W-1:0] count_step;
  wire ctl_count_en;
  wire ctl_irq_en;
  wire ctl_auto_inc;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  gtc_match #(.W(W)) u_match (
    .count(count),
    .compare(compare),
    .cmp_en(control[`GTC_CTL_CMP_EN]),
    .hit(hit)
  );

  // A match event is the rising edge of reached, and only one per arming unless auto-increment is on
  assign match_evt = hit && !prev_hit && armed;
  assign access = psel && penable;
  assign wr = access && pwrite;

  // Write strobe for one register, at the edge where the access completes
  function wr_sel;
    input done;
    input [11:0] addr;
    input [11:0] target;
    begin
      wr_sel = done && (addr == target);
    end
  endfunction

  assign wr_done = wr && pready;
  assign wr_count_lo = wr_sel(wr_done, paddr, `GTC_ADDR_COUNT_LO);
  assign wr_count_hi = wr_sel(wr_done, paddr, `GTC_ADDR_COUNT_HI);
  assign wr_control = wr_sel(wr_done, paddr, `GTC_ADDR_CONTROL);
  assign wr_event = wr_sel(wr_done, paddr, `GTC_ADDR_EVENT);
  assign wr_cmp_lo = wr_sel(wr_done, paddr, `GTC_ADDR_CMP_LO);
  assign wr_cmp_hi = wr_sel(wr_done, paddr, `GTC_ADDR_CMP_HI);
  assign wr_incr = wr_sel(wr_done, paddr, `GTC_ADDR_INCR);
  assign wr_mask = wr_sel(wr_done, paddr, `GTC_ADDR_MASK);
  assign clr_evt = wr_event && pwdata[`GTC_EVT_MATCH];
  // Set beats a write-one clear in the same cycle
  assign next_event_flag = match_evt || (event_flag && !clr_evt);
  assign count_step = {{(W-1){1'b0}}, 1'b1};
  assign ctl_count_en = control[`GTC_CTL_COUNT_EN];
  assign ctl_irq_en = control[`GTC_CTL_IRQ_EN];
  assign ctl_auto_inc = control[`GTC_CTL_AUTO_INC];

  function [31:0] pick;
    input [W-1:0] v;
    input hi;
    begin
      pick = hi ? v[63:32] : v[31:0];
    end
  endfunction

  always @* begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (paddr)
      `GTC_ADDR_COUNT_LO: next_rdata = pick(count, 1'b0);
      `GTC_ADDR_COUNT_HI: next_rdata = pick(count, 1'b1);
      `GTC_ADDR_CONTROL: next_rdata = {28'h0, control};
      `GTC_ADDR_EVENT: next_rdata = {31'h0, event_flag};
      `GTC_ADDR_CMP_LO: next_rdata = pick(compare, 1'b0);
      `GTC_ADDR_CMP_HI: next_rdata = pick(compare, 1'b1);
      `GTC_ADDR_INCR: next_rdata = incr;
      `GTC_ADDR_MASK: next_rdata = {31'h0, mask};
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // One wait state: answer in the second access cycle
      pready <= access && !pready;
      pslverr <= access && !pready && next_err;
      prdata <= (access && !pready && !pwrite) ? next_rdata : 32'h0;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prev_hit <= 1'b0;
    end else begin
      prev_hit <= hit;
    end
  end

  // Software writes take priority over counting
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count <= {W{1'b0}};
    end else if (wr_count_lo) begin
      count[31:0] <= pwdata;
    end else if (wr_count_hi) begin
      count[63:32] <= pwdata;
    end else if (ctl_count_en) begin
      count <= count + count_step;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      control <= `GTC_CTL_RESET;
    end else if (wr_control) begin
      control <= pwdata[`GTC_CTL_WIDTH-1:0];
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      incr <= 32'h0;
    end else if (wr_incr) begin
      incr <= pwdata;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask <= `GTC_MASK_RESET;
    end else if (wr_mask) begin
      mask <= pwdata[0];
    end
  end

  // Rewriting the comparator rearms single-shot detection
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      compare <= {W{1'b0}};
      armed <= 1'b1;
    end else if (wr_cmp_lo) begin
      compare[31:0] <= pwdata;
      armed <= 1'b1;
    end else if (wr_cmp_hi) begin
      compare[63:32] <= pwdata;
      armed <= 1'b1;
    end else if (match_evt && ctl_auto_inc) begin
      compare <= compare + {32'h0, incr};
    end else if (match_evt) begin
      armed <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      event_flag <= 1'b0;
    end else begin
      event_flag <= next_event_flag;
    end
  end

  // Level request follows the flag, gated by its enable and the mask
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_event_flag && ctl_irq_en && mask;
    end
  end
endmodule
`default_nettype wire

// *** verification/gtc_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
module gtc_cpu (
  input wire logic clk,
  input wire logic pready,
  input wire logic irq,
  output logic psel = 1'h0,
  output logic penable = 1'h0,
  output logic pwrite = 1'h0,
  output logic [11:0] paddr = 12'h0,
  output logic [31:0] pwdata = 32'h0
);
  int n_pend27 = 0;
  int n_req = 0;
  logic irq_d = 1'b0;
  // Interrupt controller side: each rising request becomes one pending entry
  always @(posedge clk) begin
    irq_d <= irq;
    if (irq === 1'b1 && irq_d === 1'b0) n_req <= n_req + 1;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable, pwdata} <= {2'h0, ~d};
    @(posedge clk);
  endtask
  task automatic isr(input logic [31:0] c);
    xfer(1'b1, 12'h010, c);
    xfer(1'b1, 12'h00c, 32'h1);
    n_pend27++;
  endtask
endmodule
`default_nettype wire

// *** verification/gtc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module gtc_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata
);
  logic clr_done;
  logic gate_done;
  // A flag clear drops the request at once, an enable or mask write one cycle later
  assign clr_done = pready & pwrite & (paddr == 12'h00c) & pwdata[0];
  assign gate_done = pready & pwrite & ((paddr == 12'h008) | (paddr == 12'h01c));
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_irq_hold: assert property ($fell(irq) |-> $past(clr_done) | $past(gate_done, 2))
    else $error("irq drop");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_rdy_lat: assert property ($rose(penable) & psel |=> pready) else $error("late ready");
  a_rdy_acc: assert property (pready |-> psel & penable) else $error("stray ready");
  a_setup_wait: assert property (psel & !penable |-> !pready) else $error("early ready");
  a_err_map: assert property (pready & paddr < 12'h020 & paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad err");
  a_err_unmap: assert property (pready & paddr > 12'h01c |-> pslverr & prdata == 32'h0) else $error("no err");
  a_rd_idle: assert property (!pready |-> prdata == 32'h0 & !pslverr) else $error("idle data");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_wr: cover property (pready & pwrite);
endmodule
bind gtc_timer gtc_props u_props (.clk, .rst_n, .psel, .penable, .pwrite, .pready, .pslverr, .irq, .paddr, .pwdata, .prdata);
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, c, r;
  logic [32:0] q[$];
  int n_errors = 0, num_checks = 0, cyc = 0, n_seen = 0;
  always #20 clk = ~clk;
  gtc_timer uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  gtc_cpu cpu (.clk, .pready, .irq, .psel, .penable, .pwrite, .paddr, .pwdata);
  task automatic chk(input logic ok);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH %0t bad value", $time);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    cpu.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d);
  endtask
  task automatic wirq();
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
  endtask
  always @(posedge clk) if (++cyc == 4000) begin
    n_errors++;
    summarize();
  end
  always @(posedge clk) if (pready === 1'b1 && !pwrite) chk({pslverr, prdata} === q.pop_front());
  initial begin
    void'($urandom(32));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(12'h000, 33'h0);
    rd(12'h01c, 33'h1);
    rd(12'h020, 33'h100000000);
    c = 32'd60 + $urandom % 40;
    wr(12'h010, c);
    wr(12'h014, 32'h0);
    wr(12'h008, 32'h7);
    wirq();
    chk(irq === 1'b1);
    rd(12'h00c, 33'h1);
    rd(12'h010, {1'b0, c});
    cpu.isr(c + 32'd400);
    repeat (100) @(posedge clk);
    chk(irq === 1'b0);
    chk(cpu.n_req == cpu.n_pend27);
    wr(12'h018, 32'h14);
    wr(12'h008, 32'hf);
    wirq();
    wr(12'h00c, 32'h1);
    @(posedge clk);
    chk(irq === 1'b0);
    wirq();
    chk(irq === 1'b1);
    wr(12'h008, 32'hb);
    @(posedge clk);
    chk(irq === 1'b0);
    wr(12'h008, 32'h0);
    r = $urandom & 32'h7fffffff;
    wr(12'h000, r);
    wr(12'h004, 32'h0);
    repeat (20) @(posedge clk);
    rd(12'h000, {1'b0, r});
    wr(12'h00c, 32'h1);
    wr(12'h010, r + 32'h5);
    wr(12'h014, 32'h0);
    wr(12'h008, 32'h5);
    repeat (40) @(posedge clk);
    chk(irq === 1'b0);
    rd(12'h00c, 33'h0);
    wr(12'h008, 32'h7);
    wirq();
    chk(irq === 1'b1);
    wr(12'h00c, 32'h1);
    n_seen = cpu.n_req;
    wr(12'h010, r + 32'h1388);
    repeat (100) @(posedge clk);
    chk(irq === 1'b0);
    chk(cpu.n_req == n_seen);
    summarize();
  end
endmodule
`default_nettype wire
